// ### src/tcr_pkg.sv
// translation control register decode: shared constants and types
// assumes one 100 MHz clock, synchronous active-high reset
// ============================================================
// Overview of operation
// - upper walk disable set and a miss on the upper base gives a level-1 fault, no walk.
// - lower walk disable set and a miss on the lower base gives a level-1 fault, no walk.
// - both walk disables must be written zero when effective extended enable is 0 or hyp.
// - the asid select bit picks the asid from the lower (0) or upper (1) base register.
// - 32-bit layout size offsets are 3 bits at 18:16 and 2:0, size 2^(32-offset).
// - 64-bit layout size offsets are 6 bits at 21:16 and 5:0, size 2^(64-offset).
// - shareability decodes 00 non, 01 unpredictable, 10 outer, 11 inner.
// - cacheability decodes 00 non-cacheable, 01 wb-wa, 10 wt, 11 wb no-wa.
// - lower walk non-secure attribute at bit 14 acts only in a secure bank (32-bit layout).
// - wide address select picks the 64-bit scheme and its field layout.
// - upper granule at 31:30 decodes 01 16KB, 10 4KB, 11 64KB, 00 reserved.
// - lower granule at 15:14 decodes 00 4KB, 01 64KB, 10 16KB, 11 reserved.
// - a reserved granule acts as a chosen implemented size; readback shows programmed value.
// - extended walk disables act as the short ones, at positions set by effective enable.
// - effective extended enable is the bit, stage 2, 64-bit scheme or a hypervisor bank.
package tcr_pkg;
    // ============================================================
    // register map
    localparam logic [3:0]  ADDR_TCR       = 4'h0;
    localparam logic [3:0]  ADDR_STATUS    = 4'h4;
    localparam logic [3:0]  ADDR_MASK      = 4'h8;
    localparam logic [3:0]  ADDR_CFG       = 4'hc;
    localparam logic [31:0] TCR_RESET      = 32'h0000_0000;
    // writable masks per layout, reserved bits stay zero
    localparam logic [31:0] WMASK_SHORT    = 32'hc000_403f;
    localparam logic [31:0] WMASK_LONG     = 32'hffc7_7f87;
    localparam logic [31:0] WMASK_WIDE     = 32'hffff_ffbf;
    // field positions
    localparam int EAE_BIT   = 31;
    localparam int UWD_BIT   = 23;
    localparam int ASEL_BIT  = 22;
    localparam int LWD_BIT   = 7;
    localparam int NS0_BIT   = 14;
    localparam int SPD1_BIT  = 5;
    localparam int SPD0_BIT  = 4;
    // status bits
    localparam int EV_UFAULT = 0;
    localparam int EV_LFAULT = 1;
    localparam int EV_SBZ    = 2;
    // granule encodings
    typedef enum logic [1:0] {
        GRAN_4K  = 2'h0,
        GRAN_16K = 2'h1,
        GRAN_64K = 2'h2
    } gran_type;
    // granule chosen for reserved codes
    localparam gran_type GRAN_FALLBACK = GRAN_4K;
    typedef enum logic [1:0] {
        SH_NON = 2'h0, SH_UNP = 2'h1, SH_OUTER = 2'h2, SH_INNER = 2'h3
    } share_type;
    typedef enum logic [1:0] {
        CA_NC = 2'h0, CA_WBWA = 2'h1, CA_WT = 2'h2, CA_WBNA = 2'h3
    } cache_type;
endpackage : tcr_pkg

// ### src/tcr_fields_if.sv
// decoded field bundle between decode and miss logic
// assumes the package is compiled first
`timescale 1ns/1ps
interface tcr_fields_if;
    import tcr_pkg::*;
    logic      upper_walk_disable;
    logic      lower_walk_disable;
    logic      asid_source_select;
    logic      lower_walk_nonsecure_attr;
    logic [6:0] upper_region_bits;
    logic [6:0] lower_region_bits;
    gran_type  upper_granule_size;
    gran_type  lower_granule_size;
    modport producer (output upper_walk_disable, lower_walk_disable, asid_source_select,
                      lower_walk_nonsecure_attr, upper_region_bits, lower_region_bits,
                      upper_granule_size, lower_granule_size);
    modport consumer (input upper_walk_disable, lower_walk_disable, asid_source_select,
                      lower_walk_nonsecure_attr, upper_region_bits, lower_region_bits,
                      upper_granule_size, lower_granule_size);
endinterface : tcr_fields_if

// ### src/tcr_field_decode.sv
// layout decode of the stored control word
// assumes the word is already masked to the active layout
`timescale 1ns/1ps
module tcr_field_decode
    import tcr_pkg::*;
(
    input  wire logic [31:0] tcr_word,
    input  wire logic        wide_mode,
    input  wire logic        eae_eff,
    input  wire logic        secure_bank,
    tcr_fields_if.producer   fld
);
    // ============================================================
    // field selection per layout
    always_comb begin
        // short layout keeps its disables at bits 5 and 4
        fld.upper_walk_disable = eae_eff ? tcr_word[UWD_BIT] : tcr_word[SPD1_BIT];
        fld.lower_walk_disable = eae_eff ? tcr_word[LWD_BIT] : tcr_word[SPD0_BIT];
        fld.asid_source_select = tcr_word[ASEL_BIT];
        // ignored outside secure banks; 32-bit layouts only
        fld.lower_walk_nonsecure_attr = !wide_mode && secure_bank && tcr_word[NS0_BIT];
        if (wide_mode) begin
            // size = 64 - offset
            fld.upper_region_bits = 7'd64 - {1'b0, tcr_word[21:16]};
            fld.lower_region_bits = 7'd64 - {1'b0, tcr_word[5:0]};
            unique case (tcr_word[31:30])
                2'h1:    fld.upper_granule_size = GRAN_16K;
                2'h2:    fld.upper_granule_size = GRAN_4K;
                2'h3:    fld.upper_granule_size = GRAN_64K;
                default: fld.upper_granule_size = GRAN_FALLBACK;
            endcase
            unique case (tcr_word[15:14])
                2'h0:    fld.lower_granule_size = GRAN_4K;
                2'h1:    fld.lower_granule_size = GRAN_64K;
                2'h2:    fld.lower_granule_size = GRAN_16K;
                default: fld.lower_granule_size = GRAN_FALLBACK;
            endcase
        end else begin
            fld.upper_region_bits = 7'd32 - {4'h0, tcr_word[18:16]};
            fld.lower_region_bits = 7'd32 - {4'h0, tcr_word[2:0]};
            fld.upper_granule_size = GRAN_4K;
            fld.lower_granule_size = GRAN_4K;
        end
    end
endmodule : tcr_field_decode

// ### src/tcr_attr_decode.sv
// walk attribute decode for one region
// assumes fields already selected by the caller
`timescale 1ns/1ps
module tcr_attr_decode
    import tcr_pkg::*;
(
    input  wire logic [1:0] share_field,
    input  wire logic [1:0] outer_field,
    input  wire logic [1:0] inner_field,
    output share_type       share,
    output cache_type       outer,
    output cache_type       inner
);
    // ============================================================
    // encodings map one to one onto the enums
    always_comb begin
        share = share_type'(share_field);
        outer = cache_type'(outer_field);
        inner = cache_type'(inner_field);
    end
endmodule : tcr_attr_decode

// ### src/context_translation_control.sv
// top: translation control register, layout decode and miss decision
// assumes a plain one-cycle register port and synchronous miss requests
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module context_translation_control
    import tcr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic        wide_address_select,
    input  wire logic        hypervisor_bank,
    input  wire logic        monitor_bank,
    input  wire logic        secure_bank,
    input  wire logic        stage2_active,
    input  wire logic        miss_valid,
    input  wire logic        miss_uses_upper,
    output logic             walk_start,
    output logic             walk_fault,
    output logic             asid_from_upper,
    output logic      [6:0]  region_bits,
    output gran_type         granule_size,
    output share_type        walk_share,
    output cache_type        walk_outer,
    output cache_type        walk_inner,
    output logic             walk_nonsecure,
    output logic             irq
);
    // ============================================================
    // register state
    logic [31:0] tcr_r, tcr_nxt;
    logic [2:0]  status_r, status_nxt;
    logic [2:0]  mask_r, mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        walk_start_r, walk_start_nxt;
    logic        walk_fault_r, walk_fault_nxt;
    logic        asid_r, asid_nxt;
    logic [6:0]  region_r, region_nxt;
    gran_type    gran_r, gran_nxt;
    share_type   share_r, share_nxt;
    cache_type   outer_r, outer_nxt;
    cache_type   inner_r, inner_nxt;
    logic        ns_r, ns_nxt;
    logic        eae_eff;
    logic [31:0] wmask;
    logic [2:0]  events;
    share_type   ushare, lshare;
    cache_type   uouter, uinner, louter, linner;
    tcr_fields_if fld ();

    // effective extended-address enable
    assign eae_eff = tcr_r[EAE_BIT] | stage2_active | wide_address_select
                   | hypervisor_bank;

    // layout selects which bits software may set; the rest read zero
    always_comb begin
        if (wide_address_select) begin
            wmask = WMASK_WIDE;
        end else if (tcr_r[EAE_BIT] || reg_wdata[EAE_BIT]) begin
            wmask = WMASK_LONG;
        end else begin
            wmask = WMASK_SHORT;
        end
    end

    // ============================================================
    // field and attribute decoders
    tcr_field_decode u_fields (
        .tcr_word    (tcr_r),
        .wide_mode   (wide_address_select),
        .eae_eff     (eae_eff),
        .secure_bank (secure_bank),
        .fld         (fld)
    );
    tcr_attr_decode u_upper_attr (
        .share_field (tcr_r[29:28]),
        .outer_field (tcr_r[27:26]),
        .inner_field (tcr_r[25:24]),
        .share       (ushare),
        .outer       (uouter),
        .inner       (uinner)
    );
    tcr_attr_decode u_lower_attr (
        .share_field (tcr_r[13:12]),
        .outer_field (tcr_r[11:10]),
        .inner_field (tcr_r[9:8]),
        .share       (lshare),
        .outer       (louter),
        .inner       (linner)
    );

    // ============================================================
    // event sources: faults and an illegal nonzero disable write
    always_comb begin
        events = 3'h0;
        events[EV_UFAULT] = miss_valid && miss_uses_upper && fld.upper_walk_disable;
        events[EV_LFAULT] = miss_valid && !miss_uses_upper && fld.lower_walk_disable;
        // flag only; the write still lands, so readback shows it unless the short mask drops bits 23 and 7
        // a hyp bank forbids the disables even when bit 31 is written set
        events[EV_SBZ] = reg_write && reg_addr == ADDR_TCR
                       && (hypervisor_bank || (!eae_eff && !reg_wdata[EAE_BIT]))
                       && (reg_wdata[UWD_BIT] || reg_wdata[LWD_BIT]);
    end

    // ============================================================
    // register file next state
    always_comb begin
        tcr_nxt    = tcr_r;
        mask_nxt   = mask_r;
        status_nxt = status_r;
        rdata_nxt  = 32'h0000_0000;
        if (reg_write) begin
            unique case (reg_addr)
                ADDR_TCR:  tcr_nxt = reg_wdata & wmask;
                ADDR_MASK: mask_nxt = reg_wdata[2:0];
                // write one to clear
                ADDR_STATUS: status_nxt = status_r & ~reg_wdata[2:0];
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        status_nxt = status_nxt | events;
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_TCR:    rdata_nxt = tcr_r;
                ADDR_STATUS: rdata_nxt = {29'h0, status_r};
                ADDR_MASK:   rdata_nxt = {29'h0, mask_r};
                ADDR_CFG:    rdata_nxt = {25'h0, fld.upper_region_bits};
                default:     rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ============================================================
    // miss decision: fault or walk, with region attributes
    always_comb begin
        walk_start_nxt = 1'b0;
        walk_fault_nxt = 1'b0;
        asid_nxt   = fld.asid_source_select;
        region_nxt = region_r;
        gran_nxt   = gran_r;
        share_nxt  = share_r;
        outer_nxt  = outer_r;
        inner_nxt  = inner_r;
        ns_nxt     = ns_r;
        if (miss_valid) begin
            if (miss_uses_upper) begin
                walk_fault_nxt = fld.upper_walk_disable;
                walk_start_nxt = !fld.upper_walk_disable;
                region_nxt = fld.upper_region_bits;
                // upper granule only for stage 1 outside hyp and monitor
                gran_nxt = (hypervisor_bank || monitor_bank || stage2_active)
                         ? GRAN_FALLBACK : fld.upper_granule_size;
                share_nxt = ushare;
                outer_nxt = uouter;
                inner_nxt = uinner;
                ns_nxt = 1'b0;
            end else begin
                walk_fault_nxt = fld.lower_walk_disable;
                walk_start_nxt = !fld.lower_walk_disable;
                region_nxt = fld.lower_region_bits;
                gran_nxt  = fld.lower_granule_size;
                share_nxt = lshare;
                outer_nxt = louter;
                inner_nxt = linner;
                ns_nxt = fld.lower_walk_nonsecure_attr;
            end
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tcr_r        <= TCR_RESET;
            status_r     <= 3'h0;
            mask_r       <= 3'h0;
            rdata_r      <= 32'h0000_0000;
            walk_start_r <= 1'b0;
            walk_fault_r <= 1'b0;
            asid_r       <= 1'b0;
            region_r     <= 7'h00;
            gran_r       <= GRAN_4K;
            share_r      <= SH_NON;
            outer_r      <= CA_NC;
            inner_r      <= CA_NC;
            ns_r         <= 1'b0;
        end else begin
            tcr_r        <= tcr_nxt;
            status_r     <= status_nxt;
            mask_r       <= mask_nxt;
            rdata_r      <= rdata_nxt;
            walk_start_r <= walk_start_nxt;
            walk_fault_r <= walk_fault_nxt;
            asid_r       <= asid_nxt;
            region_r     <= region_nxt;
            gran_r       <= gran_nxt;
            share_r      <= share_nxt;
            outer_r      <= outer_nxt;
            inner_r      <= inner_nxt;
            ns_r         <= ns_nxt;
        end
    end

    // outputs straight from flip-flops, irq through a gate over them
    assign reg_rdata       = rdata_r;
    assign walk_start      = walk_start_r;
    assign walk_fault      = walk_fault_r;
    assign asid_from_upper = asid_r;
    assign region_bits     = region_r;
    assign granule_size    = gran_r;
    assign walk_share      = share_r;
    assign walk_outer      = outer_r;
    assign walk_inner      = inner_r;
    assign walk_nonsecure  = ns_r;
    assign irq             = |(status_r & mask_r); // level, unmasked sticky bits
endmodule : context_translation_control

// ### test/context_translation_control_props.sv
// checker: bus, miss and interrupt timing of the translation control block
// assumes only the top module ports; bound to the top at the foot of this file
`timescale 1ns/1ps
module tcr_ctl_props
    import tcr_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        wide_address_select,
    input wire logic        hypervisor_bank,
    input wire logic        monitor_bank,
    input wire logic        secure_bank,
    input wire logic        stage2_active,
    input wire logic        miss_valid,
    input wire logic        miss_uses_upper,
    input wire logic        walk_start,
    input wire logic        walk_fault,
    input wire logic [6:0]  region_bits,
    input gran_type         granule_size,
    input share_type        walk_share,
    input wire logic        walk_nonsecure,
    input wire logic        irq
);
    // ============================================================
    // clocking
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // short-layout writes are left out: their mask depends on the stored word
    sequence s_wr_rd;
        reg_write && reg_addr == ADDR_TCR && (wide_address_select || reg_wdata[31])
        ##1 reg_read && reg_addr == ADDR_TCR;
    endsequence
    // ============================================================
    // assertions
    chk_miss_answer: assert property (miss_valid |=> walk_start != walk_fault)
        else $error("miss not answered by one walk or one fault");
    chk_no_spurious: assert property (!miss_valid |=> !walk_start && !walk_fault)
        else $error("walk or fault without a miss");
    chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data outside the read answer cycle");
    chk_tcr_readback: assert property (s_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) &
        ($past(wide_address_select, 2) ? WMASK_WIDE : WMASK_LONG)))
        else $error("control readback not the masked written word");
    chk_attr_hold: assert property (!miss_valid |=> $stable(region_bits) &&
        $stable(walk_share) && $stable(granule_size))
        else $error("walk attributes moved without a miss");
    chk_region_narrow: assert property (miss_valid && !wide_address_select |=>
        region_bits inside {[25:32]})
        else $error("narrow region size out of range");
    chk_region_wide: assert property (miss_valid && wide_address_select |=>
        region_bits inside {[1:64]})
        else $error("wide region size out of range");
    chk_upper_gran_fixed: assert property (miss_valid && miss_uses_upper &&
        (hypervisor_bank || monitor_bank || stage2_active) |=> granule_size == GRAN_4K)
        else $error("upper granule not fixed for this bank");
    chk_ns_gate: assert property (miss_valid && (!secure_bank || wide_address_select)
        |=> !walk_nonsecure)
        else $error("non-secure walk attribute outside a narrow secure bank");
    chk_irq_cause: assert property ($rose(irq) |->
        $past(reg_write) || walk_fault || $past(walk_fault))
        else $error("interrupt rose without a fault or a write");
    cover property (miss_valid && !miss_uses_upper ##1 walk_fault);
    cover property (miss_valid && wide_address_select ##1 walk_start);
    cover property ($rose(irq));
endmodule : tcr_ctl_props

bind context_translation_control tcr_ctl_props u_props (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .wide_address_select(wide_address_select), .hypervisor_bank(hypervisor_bank),
    .monitor_bank(monitor_bank), .secure_bank(secure_bank), .stage2_active(stage2_active),
    .miss_valid(miss_valid), .miss_uses_upper(miss_uses_upper), .walk_start(walk_start),
    .walk_fault(walk_fault), .region_bits(region_bits), .granule_size(granule_size),
    .walk_share(walk_share), .walk_nonsecure(walk_nonsecure), .irq(irq));

// ### test/test_context_translation_control.sv
// testbench: register port, miss decode and interrupt of the control block
// assumes package and design compiled ahead of it, checker bound separately
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %s expected %0h seen %0h", n, e, a); end end
module test_context_translation_control;
    import tcr_pkg::*;
    logic        core_clk, reset, reg_write, reg_read, miss_valid, miss_uses_upper;
    logic        wide, hyp, mon, sec, st2, walk_start, walk_fault, asid_up, walk_ns, irq;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, w;
    logic [6:0]  region_bits;
    logic [1:0]  c;
    gran_type    granule_size;
    share_type   walk_share;
    cache_type   walk_outer, walk_inner;
    int          bad_count, checks_done;
    gran_type    up_g[4] = '{GRAN_4K, GRAN_16K, GRAN_4K, GRAN_64K};
    gran_type    lo_g[4] = '{GRAN_4K, GRAN_64K, GRAN_16K, GRAN_4K};

    context_translation_control DUT (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .wide_address_select(wide), .hypervisor_bank(hyp), .monitor_bank(mon),
        .secure_bank(sec), .stage2_active(st2), .miss_valid(miss_valid),
        .miss_uses_upper(miss_uses_upper), .walk_start(walk_start), .walk_fault(walk_fault),
        .asid_from_upper(asid_up), .region_bits(region_bits), .granule_size(granule_size),
        .walk_share(walk_share), .walk_outer(walk_outer), .walk_inner(walk_inner),
        .walk_nonsecure(walk_ns), .irq(irq));

    // ============================================================
    // port tasks: every cycle is driven whole, so no strobe is set twice in a step
    task automatic drv(input logic ws, rs, m, up, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_write <= ws;
        reg_read <= rs;
        miss_valid <= m;
        miss_uses_upper <= up;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : drv
    task automatic idle();
        drv(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 32'h0);
        #1;
    endtask : idle
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        drv(1'b1, 1'b0, 1'b0, 1'b0, a, d);
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        drv(1'b0, 1'b1, 1'b0, 1'b0, a, 32'h0);
        idle();
        `CHK("rdata", e, reg_rdata)
    endtask : rd
    task automatic miss(input logic up, s, f, input logic [6:0] r);
        drv(1'b0, 1'b0, 1'b1, up, 4'h0, 32'h0);
        idle();
        `CHK("start", s, walk_start)
        `CHK("fault", f, walk_fault)
        `CHK("region", r, region_bits)
    endtask : miss
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // ============================================================
    // clock and watchdog (whole run is under a hundred cycles)
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        bad_count++;
        stop_test();
    end
    // ============================================================
    // scenarios
    initial begin
        {reset, reg_write, reg_read, miss_valid, miss_uses_upper} = 5'h10;
        {wide, hyp, mon, sec, st2} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd(ADDR_TCR, 32'h0);
        rd(4'h1, 32'h0);
        // long layout with reserved bits written as ones
        sec <= 1'b1;
        wr(ADDR_TCR, 32'ha67b_dbfd);
        rd(ADDR_TCR, 32'ha67b_dbfd & WMASK_LONG);
        wr(ADDR_MASK, 32'h7);
        miss(1'b0, 1'b0, 1'b1, 7'd27);
        `CHK("share", SH_UNP, walk_share)
        `CHK("outer", CA_WT, walk_outer)
        `CHK("inner", CA_WBNA, walk_inner)
        `CHK("ns", 1'b1, walk_ns)
        `CHK("asid", 1'b1, asid_up)
        miss(1'b1, 1'b1, 1'b0, 7'd29);
        `CHK("share", SH_OUTER, walk_share)
        `CHK("outer", CA_WBWA, walk_outer)
        rd(ADDR_STATUS, 32'h2);
        `CHK("irq", 1'b1, irq)
        wr(ADDR_STATUS, 32'h2);
        rd(ADDR_STATUS, 32'h0);
        `CHK("irq", 1'b0, irq)
        // masked fault in a non-secure bank, then unmasked
        sec <= 1'b0;
        wr(ADDR_MASK, 32'h4);
        miss(1'b0, 1'b0, 1'b1, 7'd27);
        `CHK("ns", 1'b0, walk_ns)
        rd(ADDR_STATUS, 32'h2);
        `CHK("irq", 1'b0, irq)
        wr(ADDR_MASK, 32'h2);
        idle();
        `CHK("irq", 1'b1, irq)
        // wide layout, upper size 48 with its walk disabled, lower size at its smallest
        {wide, sec} <= 2'b11;
        wr(ADDR_TCR, 32'h0090_007f);
        rd(ADDR_TCR, 32'h0090_007f & WMASK_WIDE);
        rd(ADDR_CFG, 32'h0000_0030);
        miss(1'b1, 1'b0, 1'b1, 7'd48);
        `CHK("asid", 1'b0, asid_up)
        miss(1'b0, 1'b1, 1'b0, 7'd1);
        `CHK("ns", 1'b0, walk_ns)
        // every granule, shareability and cacheability code
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            w = {c, c, c, c, 8'h00, c, c, c, c, 8'h00};
            wr(ADDR_TCR, w);
            rd(ADDR_TCR, w);
            miss(1'b1, 1'b1, 1'b0, 7'd64);
            `CHK("ugran", up_g[i], granule_size)
            `CHK("share", share_type'(c), walk_share)
            `CHK("outer", cache_type'(c), walk_outer)
            miss(1'b0, 1'b1, 1'b0, 7'd64);
            `CHK("lgran", lo_g[i], granule_size)
            `CHK("inner", cache_type'(c), walk_inner)
        end
        // upper granule fixed for second-stage, monitor and hypervisor work
        for (int k = 0; k < 3; k++) begin
            {st2, mon, hyp} <= 3'b001 << k;
            miss(1'b1, 1'b1, 1'b0, 7'd64);
            `CHK("ugran", GRAN_4K, granule_size)
        end
        // short layout: low disables act until the effective enable rises
        {wide, hyp, mon, st2} <= 4'h0;
        // clear bit 31 first: while it is stored a write still takes the long mask
        wr(ADDR_TCR, 32'h0000_0000);
        wr(ADDR_TCR, 32'h0000_0030);
        miss(1'b1, 1'b0, 1'b1, 7'd32);
        miss(1'b0, 1'b0, 1'b1, 7'd32);
        st2 <= 1'b1;
        miss(1'b1, 1'b1, 1'b0, 7'd32);
        {st2, hyp} <= 2'b01;
        miss(1'b0, 1'b1, 1'b0, 7'd32);
        // walk disables written while they must stay zero
        wr(ADDR_STATUS, 32'h7);
        wr(ADDR_MASK, 32'h4);
        hyp <= 1'b0;
        wr(ADDR_TCR, 32'h0000_0080);
        rd(ADDR_STATUS, 32'h4);
        `CHK("irq", 1'b1, irq)
        wr(ADDR_STATUS, 32'h4);
        hyp <= 1'b1;
        wr(ADDR_TCR, 32'h8080_0000);
        rd(ADDR_STATUS, 32'h4);
        stop_test();
    end
endmodule : test_context_translation_control
